// File: rtl/fifo_offset_program_retransmit.sv
// Flag-offset programming (serial and parallel) and retransmit control.
// Assumes the FIFO pins and their write and read clocks are slow against
// clk; all pins but memEmptyN and memFirstWord are synchronised and clock edges detected here.
`timescale 1ns/1ns
module fifo_offset_program_retransmit
  import fifo_offset_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        wrClk,
  input  wire logic        rdClk,
  input  wire logic        masterResetN,
  input  wire logic        partialResetN,
  input  wire logic        offsetLoadSelectN,
  input  wire logic        serialLoadEnableN,
  input  wire logic        writeEnableN,
  input  wire logic        readEnableN,
  input  wire logic        retransmitRequestN,
  input  wire logic        serialIn,
  input  wire logic [8:0]  dataInBus,
  input  wire logic        memEmptyN,
  input  wire logic [8:0]  memFirstWord,
  output logic [8:0]       dataOutBus,
  output logic             emptyFlagN,
  output logic             fallThroughMode,
  output logic             serialMethod,
  output logic [13:0]      emptyOffset,
  output logic [13:0]      fullOffset,
  output logic             almostEmptyValid,
  output logic             almostFullValid,
  output logic             readPtrRewind,
  output logic             halfFullUpdate,
  output logic             almostEmptyUpdate,
  output logic             almostFullUpdate
);
  localparam int PINS = 19;

  logic [PINS-1:0]  pinMeta_q;
  logic [PINS-1:0]  pinSync_q;
  logic             wrClkPrev_q;
  logic             rdClkPrev_q;
  logic             wrRise;
  logic             rdRise;
  logic             mrsActive;
  logic             prsActive;
  logic             ldS;
  logic             senS;
  logic             wenS;
  logic             renS;
  logic             rtS;
  logic             serS;
  logic [8:0]       dinS;
  logic             serialMethod_q;
  logic             fall_through_mode_q;
  logic [27:0]      offsets_q;
  logic [4:0]       serialCnt_q;
  logic [1:0]       wrPtr_q;
  logic [1:0]       rdPtr_q;
  logic             serialShift;
  logic             parallelWrite;
  logic             parallelRead;
  logic             aeStart;
  logic             afStart;
  logic             aeDone;
  logic             afDone;
  logic             aeValid_q;
  logic             afValid_q;
  logic [1:0]       aeWait_q;
  logic [1:0]       afWait_q;
  rt_state_t        rtState_q;
  logic [1:0]       rtCnt_q;
  logic             rtStart;
  logic             rtDone;
  logic             softRt_q;
  logic [1:0]       aeUpdCnt_q;
  logic [1:0]       afUpdCnt_q;
  logic [8:0]       dataOut_q;
  logic             emptyFlag_q;
  logic             rewind_q;
  logic             hfUpd_q;
  logic             aeUpd_q;
  logic             afUpd_q;
  logic             pready_q;
  logic [31:0]      prdata_q;
  logic             pslverr_q;
  logic             apbAccess;
  logic             apbWrite;
  logic [31:0]      rdMux;
  logic             rdHit;

  // Two-stage synchroniser for every pin but memEmptyN and memFirstWord
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pinMeta_q <= '0;
      pinSync_q <= '0;
    end else begin
      pinMeta_q <= {wrClk, rdClk, masterResetN, partialResetN,
                    offsetLoadSelectN, serialLoadEnableN, writeEnableN,
                    readEnableN, retransmitRequestN, serialIn, dataInBus};
      pinSync_q <= pinMeta_q;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wrClkPrev_q <= 1'b0;
      rdClkPrev_q <= 1'b0;
    end else begin
      wrClkPrev_q <= pinSync_q[18];
      rdClkPrev_q <= pinSync_q[17];
    end
  end

  assign wrRise    = pinSync_q[18] & ~wrClkPrev_q;
  assign rdRise    = pinSync_q[17] & ~rdClkPrev_q;
  assign mrsActive = ~pinSync_q[16];
  assign prsActive = ~pinSync_q[15];
  assign ldS       = pinSync_q[14];
  assign senS      = pinSync_q[13];
  assign wenS      = pinSync_q[12];
  assign renS      = pinSync_q[11];
  assign rtS       = pinSync_q[10];
  assign serS      = pinSync_q[9];
  assign dinS      = pinSync_q[8:0];

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      serialMethod_q <= 1'b0;
      fall_through_mode_q         <= 1'b0;
    end else if (mrsActive) begin
      serialMethod_q <= ldS;
      fall_through_mode_q         <= serS;
    end
  end

  // shifting only with both pins low
  assign serialShift   = wrRise & serialMethod_q & ~ldS & ~senS & ~mrsActive;
  // paused whenever load select or write enable is high
  assign parallelWrite = wrRise & ~serialMethod_q & ~ldS & ~wenS & ~mrsActive;
  // readback in any mode and method, paused by either pin
  assign parallelRead  = rdRise & ~ldS & ~renS & ~mrsActive;

  // offset store; serial bit lands at its position in the sequence
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      offsets_q <= {PARALLEL_DEFAULT_OFS, PARALLEL_DEFAULT_OFS};
    end else if (mrsActive) begin
      offsets_q <= ldS ? {SERIAL_DEFAULT_OFS, SERIAL_DEFAULT_OFS}
                       : {PARALLEL_DEFAULT_OFS, PARALLEL_DEFAULT_OFS};
    end else if (serialShift) begin
      offsets_q[serialCnt_q] <= serS;
    end else if (parallelWrite) begin
      // register chosen by the write pointer
      unique case (wrPtr_q)
        OFS_EMPTY_LO: offsets_q[8:0]   <= dinS;
        OFS_EMPTY_HI: offsets_q[13:9]  <= dinS[4:0];
        OFS_FULL_LO:  offsets_q[22:14] <= dinS;
        OFS_FULL_HI:  offsets_q[27:23] <= dinS[4:0];
      endcase
    end
  end

  // serial count runs over the whole set before wrapping
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      serialCnt_q <= 5'h00;
    end else if (mrsActive) begin
      serialCnt_q <= 5'h00;
    end else if (serialShift) begin
      serialCnt_q <= (serialCnt_q == SERIAL_LAST) ? 5'h00
                                                  : serialCnt_q + 5'h01;
    end
  end

  // independent pointers, cleared by master reset only
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wrPtr_q <= OFS_EMPTY_LO;
      rdPtr_q <= OFS_EMPTY_LO;
    end else if (mrsActive) begin
      wrPtr_q <= OFS_EMPTY_LO;
      rdPtr_q <= OFS_EMPTY_LO;
    end else begin
      if (parallelWrite) begin
        wrPtr_q <= wrPtr_q + 2'h1;
      end
      if (parallelRead) begin
        rdPtr_q <= rdPtr_q + 2'h1;
      end
    end
  end

  assign aeStart = serialShift | (parallelWrite & ~wrPtr_q[1]);
  assign afStart = serialShift | (parallelWrite & wrPtr_q[1]);
  assign aeDone  = (serialShift & (serialCnt_q == SERIAL_LAST))
                 | (parallelWrite & (wrPtr_q == OFS_EMPTY_HI));
  assign afDone  = (serialShift & (serialCnt_q == SERIAL_LAST))
                 | (parallelWrite & (wrPtr_q == OFS_FULL_HI));

  // almost-empty validity waits two read edges after completion
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      aeValid_q <= 1'b1;
      aeWait_q  <= 2'h0;
    end else if (mrsActive) begin
      aeValid_q <= 1'b1;
      aeWait_q  <= 2'h0;
    end else if (aeDone) begin
      aeValid_q <= 1'b0;
      aeWait_q  <= FLAG_VALID_EDGES;
    end else if (aeStart) begin
      aeValid_q <= 1'b0;
      aeWait_q  <= 2'h0;
    end else if (rdRise && aeWait_q != 2'h0) begin
      aeWait_q  <= aeWait_q - 2'h1;
      aeValid_q <= (aeWait_q == 2'h1);
    end
  end

  // almost-full validity waits two write edges after completion
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      afValid_q <= 1'b1;
      afWait_q  <= 2'h0;
    end else if (mrsActive) begin
      afValid_q <= 1'b1;
      afWait_q  <= 2'h0;
    end else if (afDone) begin
      afValid_q <= 1'b0;
      afWait_q  <= FLAG_VALID_EDGES;
    end else if (afStart) begin
      afValid_q <= 1'b0;
      afWait_q  <= 2'h0;
    end else if (wrRise && afWait_q != 2'h0) begin
      afWait_q  <= afWait_q - 2'h1;
      afValid_q <= (afWait_q == 2'h1);
    end
  end

  // setup on a read edge with the request low, pin or software
  assign rtStart = rdRise & (~rtS | softRt_q) & (rtState_q == RT_IDLE)
                 & ~mrsActive & ~prsActive;
  assign rtDone  = rdRise & (rtState_q == RT_SETUP) & (rtCnt_q == 2'h1);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rtState_q <= RT_IDLE;
      rtCnt_q   <= 2'h0;
    end else if (mrsActive || prsActive) begin
      rtState_q <= RT_IDLE;
      rtCnt_q   <= 2'h0;
    end else begin
      unique case (rtState_q)
        RT_IDLE: begin
          if (rtStart) begin
            rtState_q <= RT_SETUP;
            rtCnt_q   <= RT_SETUP_EDGES;
          end
        end
        RT_SETUP: begin
          if (rdRise) begin
            rtCnt_q <= rtCnt_q - 2'h1;
            if (rtCnt_q == 2'h1) begin
              rtState_q <= RT_IDLE;
            end
          end
        end
      endcase
    end
  end

  // Software request is held until setup takes it or master reset clears it; a new write wins
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      softRt_q <= 1'b0;
    end else if (apbWrite && paddr == ADDR_CTRL && pwdata[CTRL_SOFT_RT]) begin
      softRt_q <= 1'b1;
    end else if (rtStart || mrsActive) begin
      softRt_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      aeUpdCnt_q <= 2'h0;
      afUpdCnt_q <= 2'h0;
      aeUpd_q    <= 1'b0;
      afUpd_q    <= 1'b0;
      hfUpd_q    <= 1'b0;
      rewind_q   <= 1'b0;
    end else begin
      hfUpd_q  <= rtStart;
      rewind_q <= rtStart;
      aeUpd_q  <= rdRise & (aeUpdCnt_q == 2'h1) & ~rtStart;
      afUpd_q  <= wrRise & (afUpdCnt_q == 2'h1) & ~rtStart;
      if (rtStart) begin
        aeUpdCnt_q <= FLAG_UPDATE_EDGES;
      end else if (rdRise && aeUpdCnt_q != 2'h0) begin
        aeUpdCnt_q <= aeUpdCnt_q - 2'h1;
      end
      if (rtStart) begin
        afUpdCnt_q <= FLAG_UPDATE_EDGES;
      end else if (wrRise && afUpdCnt_q != 2'h0) begin
        afUpdCnt_q <= afUpdCnt_q - 2'h1;
      end
    end
  end

  // empty or output-ready marking during setup
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      emptyFlag_q <= 1'b0;
    end else if (mrsActive || prsActive) begin
      emptyFlag_q <= fall_through_mode_q;
    end else if (rtStart || rtState_q == RT_SETUP) begin
      emptyFlag_q <= rtDone ? ~fall_through_mode_q : fall_through_mode_q;
    end else begin
      emptyFlag_q <= fall_through_mode_q ? ~memEmptyN : memEmptyN;
    end
  end

  // offsets reach the data outputs only here, replacing the word
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dataOut_q <= 9'h000;
    end else if (mrsActive || prsActive) begin
      dataOut_q <= 9'h000;
    end else if (parallelRead) begin
      dataOut_q <= offsetByte(rdPtr_q, offsets_q);
    end else if (rtDone && fall_through_mode_q) begin
      dataOut_q <= memFirstWord;
    end
  end

  // APB slave, one wait state
  assign apbAccess = psel & penable & ~pready_q;
  assign apbWrite  = psel & penable & pwrite & pready_q;

  always_comb begin
    rdHit = 1'b1;
    rdMux = 32'h0000_0000;
    unique case (paddr)
      ADDR_STATUS: begin
        rdMux[ST_FALL_THROUGH_MODE]              = fall_through_mode_q;
        rdMux[ST_SERIAL]            = serialMethod_q;
        rdMux[ST_AE_VALID]          = aeValid_q;
        rdMux[ST_AF_VALID]          = afValid_q;
        rdMux[ST_RT_BUSY]           = (rtState_q == RT_SETUP);
        rdMux[ST_WR_PTR +: 2]       = wrPtr_q;
        rdMux[ST_RD_PTR +: 2]       = rdPtr_q;
        rdMux[ST_SER_CNT +: 5]      = serialCnt_q;
      end
      ADDR_EMPTY_OFS: rdMux[13:0]   = offsets_q[13:0];
      ADDR_FULL_OFS:  rdMux[13:0]   = offsets_q[27:14];
      ADDR_CTRL:      rdMux[CTRL_SOFT_RT] = softRt_q;
      default:        rdHit         = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= apbAccess;
      pslverr_q <= apbAccess & ~rdHit;
      if (apbAccess) begin
        prdata_q <= pwrite ? 32'h0000_0000 : rdMux;
      end
    end
  end

  assign pready            = pready_q;
  assign prdata            = prdata_q;
  assign pslverr           = pslverr_q;
  assign dataOutBus        = dataOut_q;
  assign emptyFlagN        = emptyFlag_q;
  assign fallThroughMode   = fall_through_mode_q;
  assign serialMethod      = serialMethod_q;
  assign emptyOffset       = offsets_q[13:0];
  assign fullOffset        = offsets_q[27:14];
  assign almostEmptyValid  = aeValid_q;
  assign almostFullValid   = afValid_q;
  assign readPtrRewind     = rewind_q;
  assign halfFullUpdate    = hfUpd_q;
  assign almostEmptyUpdate = aeUpd_q;
  assign almostFullUpdate  = afUpd_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_serial_step_order: assert property (
    serialShift |=> serialCnt_q == (($past(serialCnt_q) == SERIAL_LAST)
                    ? 5'h00 : $past(serialCnt_q) + 5'h01))
    else $error("serial bit count did not advance");
  a_serial_pin_hold: assert property (
    wrRise && serialMethod_q && !ldS && senS && !mrsActive
      |=> $stable(offsets_q) && $stable(serialCnt_q))
    else $error("offset changed while serial enable high");
  a_flags_invalid_load: assert property (
    serialShift |=> !aeValid_q && !afValid_q)
    else $error("flag valid during serial load");
  a_af_valid_wait: assert property (
    afDone ##1 (!wrRise)[*2] |-> !afValid_q)
    else $error("almost-full valid too early");
  a_wr_ptr_wrap: assert property (
    parallelWrite |=> wrPtr_q == $past(wrPtr_q) + 2'h1)
    else $error("write pointer did not step");
  a_rd_data_step: assert property (
    parallelRead |=> dataOut_q == offsetByte($past(rdPtr_q), $past(offsets_q))
                     && rdPtr_q == $past(rdPtr_q) + 2'h1)
    else $error("readback word or pointer wrong");
  a_mrs_ptr_clear: assert property (
    mrsActive |=> wrPtr_q == OFS_EMPTY_LO && rdPtr_q == OFS_EMPTY_LO)
    else $error("master reset kept offset pointers");
  a_prs_ptr_keep: assert property (
    prsActive && !mrsActive && !parallelWrite && !parallelRead
      |=> $stable(wrPtr_q) && $stable(rdPtr_q))
    else $error("partial reset moved offset pointers");
  a_rt_setup_mark: assert property (
    rtStart |=> rewind_q && hfUpd_q && emptyFlag_q == fall_through_mode_q)
    else $error("retransmit setup not marked");
  a_strap_capture: assert property (
    mrsActive |=> serialMethod_q == $past(ldS) && fall_through_mode_q == $past(serS))
    else $error("strap not captured at master reset");

  c_serial_complete: cover property (serialShift && serialCnt_q == SERIAL_LAST);
  c_parallel_wrap:   cover property (parallelWrite && wrPtr_q == OFS_FULL_HI);
  c_rt_fall_through_mode_done:    cover property (rtDone && fall_through_mode_q);
endmodule : fifo_offset_program_retransmit

// File: rtl/fifo_offset_pkg.sv
// Constants, types and helpers for the flag-offset programming and
// retransmit control block. Assumes one 25 MHz system clock.
// Operation
// - Serial mode shifts one bit per write edge, empty low to full high.
// - Serial load writes all offsets; partial flags invalid until all bits in.
// - Load select low with serial enable high shifts nothing.
// - Memory writes may interleave; shifting resumes at the next bit.
// - Almost-full valid two write edges, almost-empty two read edges later.
// - Offsets are read back through the parallel output path, over APB and on the offset ports.
// - Parallel writes step empty low, empty high, full low, full high, wrap.
// - Separate write and read offset pointers; never used at once. The block does not stop a write and a read stepping both in one cycle.
// - Master reset returns both offset pointers to empty low.
// - Partial reset leaves both offset pointers where they are.
// - Parallel programming pauses via load select or write enable.
// - Parallel reads step through the four offset registers and wrap.
// - Readback pauses on read enable or load select, resumes in place.
// - An offset read overwrites the word on the data outputs.
// - Offset readback works in standard and fall-through modes.
// - Retransmit setup starts when the request is low at a read edge.
// - Standard mode: empty flag low during setup, high when complete.
// - Fall-through: ready high during setup, low with first word shown.
// - Almost-empty updates on the second read edge after setup.
// - Half-full updates at setup edge; almost-full at second write edge.
// - Load select during master reset picks serial or parallel loading.
// - Serial input during master reset picks standard or fall-through.
package fifo_offset_pkg;
  localparam int          WORD_BITS   = 9;
  localparam int          OFFSET_BITS = 14;
  localparam int          SERIAL_BITS = 2 * OFFSET_BITS;
  localparam logic [4:0]  SERIAL_LAST = 5'h1b;
  localparam logic [13:0] SERIAL_DEFAULT_OFS   = 14'h03ff;
  localparam logic [13:0] PARALLEL_DEFAULT_OFS = 14'h007f;
  localparam logic [1:0]  OFS_EMPTY_LO = 2'h0;
  localparam logic [1:0]  OFS_EMPTY_HI = 2'h1;
  localparam logic [1:0]  OFS_FULL_LO  = 2'h2;
  localparam logic [1:0]  OFS_FULL_HI  = 2'h3;
  localparam logic [1:0]  FLAG_VALID_EDGES = 2'h2;
  localparam logic [1:0]  FLAG_UPDATE_EDGES = 2'h2;
  localparam logic [1:0]  RT_SETUP_EDGES = 2'h2;
  localparam logic [7:0]  ADDR_STATUS    = 8'h00;
  localparam logic [7:0]  ADDR_EMPTY_OFS = 8'h04;
  localparam logic [7:0]  ADDR_FULL_OFS  = 8'h08;
  localparam logic [7:0]  ADDR_CTRL      = 8'h0c;
  localparam int ST_FALL_THROUGH_MODE = 0;
  localparam int ST_SERIAL = 1;
  localparam int ST_AE_VALID = 2;
  localparam int ST_AF_VALID = 3;
  localparam int ST_RT_BUSY = 4;
  localparam int ST_WR_PTR = 5;
  localparam int ST_RD_PTR = 7;
  localparam int ST_SER_CNT = 9;
  localparam int CTRL_SOFT_RT = 0;

  typedef enum logic {RT_IDLE, RT_SETUP} rt_state_t;

  // Byte view of the offset store as seen by the parallel ports
  function automatic logic [8:0] offsetByte(input logic [1:0] sel,
                                            input logic [27:0] ofs);
    logic [8:0] r;
    r = 9'h000;
    unique case (sel)
      OFS_EMPTY_LO: r = ofs[8:0];
      OFS_EMPTY_HI: r = {4'h0, ofs[13:9]};
      OFS_FULL_LO:  r = ofs[22:14];
      OFS_FULL_HI:  r = {4'h0, ofs[27:23]};
    endcase
    return r;
  endfunction : offsetByte
endpackage : fifo_offset_pkg

// File: tb/fifo_controller_model.sv
// Behavioural controller on the FIFO pin side: clocks, strobes, straps.
// Assumes its tasks are called just after a rising edge of clk.
`timescale 1ns/1ns
module fifo_controller_model (
  input  wire logic       clk,
  output logic            wrClk,
  output logic            rdClk,
  output logic            masterResetN,
  output logic            partialResetN,
  output logic            offsetLoadSelectN,
  output logic            serialLoadEnableN,
  output logic            writeEnableN,
  output logic            readEnableN,
  output logic            retransmitRequestN,
  output logic            serialIn,
  output logic [8:0]      dataInBus,
  output logic            memEmptyN,
  output logic [8:0]      memFirstWord
);
  initial begin
    {wrClk, rdClk, offsetLoadSelectN, serialIn, memEmptyN} = 5'h00;
    {masterResetN, partialResetN, serialLoadEnableN} = 3'h7;
    {writeEnableN, readEnableN, retransmitRequestN} = 3'h7;
    dataInBus = 9'h000;
    memFirstWord = 9'h000;
  end

  task automatic setPins(input logic [3:0] p, input logic si,
                         input logic [8:0] d);
    {offsetLoadSelectN, serialLoadEnableN, writeEnableN, readEnableN} <= p;
    serialIn <= si;
    dataInBus <= d;
  endtask : setPins

  // Slow clock pulse, pins stable for several cycles either side
  task automatic pulse(input logic wr);
    repeat (3) @(posedge clk);
    if (wr) wrClk <= 1'b1;
    else rdClk <= 1'b1;
    repeat (4) @(posedge clk);
    wrClk <= 1'b0;
    rdClk <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : pulse

  task automatic masterReset(input logic ld, input logic si);
    offsetLoadSelectN <= ld;
    serialIn <= si;
    masterResetN <= 1'b0;
    repeat (6) @(posedge clk);
    masterResetN <= 1'b1;
    repeat (6) @(posedge clk);
  endtask : masterReset

  task automatic partialReset();
    partialResetN <= 1'b0;
    repeat (6) @(posedge clk);
    partialResetN <= 1'b1;
    repeat (6) @(posedge clk);
  endtask : partialReset

  task automatic setMem(input logic e, input logic [8:0] w);
    memEmptyN <= e;
    memFirstWord <= w;
  endtask : setMem

  task automatic retransmit();
    readEnableN <= 1'b1;
    writeEnableN <= 1'b1;
    repeat (3) @(posedge clk);
    retransmitRequestN <= 1'b0;
    pulse(1'b0);
    retransmitRequestN <= 1'b1;
  endtask : retransmit
endmodule : fifo_controller_model

// File: tb/fifo_offset_program_retransmit_bench.sv
// Self-checking bench for offset programming and retransmit control.
// Assumes the controller model drives every FIFO pin of the block.
`timescale 1ns/1ns
module fifo_offset_program_retransmit_bench;
  import fifo_offset_pkg::*;
  localparam logic [3:0] P_WR = 4'b0101, P_RD = 4'b0110, P_SER = 4'b0011;
  localparam logic [3:0] P_IDLE = 4'b1111, P_MEMWR = 4'b1101;
  localparam logic [3:0] P_SENHI = 4'b0111, P_LDHI = 4'b1011;
  localparam logic [3:0] P_MEMRD = 4'b1110;
  // Pause patterns, applied lowest nibble first
  localparam logic [11:0] PAUSE_PAR = {P_MEMWR, P_SENHI, P_SER};
  localparam logic [11:0] PAUSE_SER = {P_SENHI, P_LDHI, P_MEMWR};
  logic        clk, rstn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdat, rndState;
  logic        wrClk, rdClk, masterResetN, partialResetN, offsetLoadSelectN;
  logic        serialLoadEnableN, writeEnableN, readEnableN, serialIn;
  logic        retransmitRequestN, memEmptyN, emptyFlagN, fallThroughMode;
  logic        serialMethod, almostEmptyValid, almostFullValid;
  logic        readPtrRewind, halfFullUpdate, almostEmptyUpdate;
  logic        almostFullUpdate;
  logic [8:0]  dataInBus, memFirstWord, dataOutBus, v;
  logic [13:0] emptyOffset, fullOffset;
  logic [8:0]  w [5];
  logic [8:0]  e [4];
  logic [27:0] s;
  int          nErrors, cmpCount;

  fifo_offset_program_retransmit DUT (.clk, .rstn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pready, .prdata, .pslverr, .wrClk, .rdClk,
    .masterResetN, .partialResetN, .offsetLoadSelectN, .serialLoadEnableN,
    .writeEnableN, .readEnableN, .retransmitRequestN, .serialIn, .dataInBus,
    .memEmptyN, .memFirstWord, .dataOutBus, .emptyFlagN, .fallThroughMode,
    .serialMethod, .emptyOffset, .fullOffset, .almostEmptyValid,
    .almostFullValid, .readPtrRewind, .halfFullUpdate, .almostEmptyUpdate,
    .almostFullUpdate);

  fifo_controller_model ctl (.clk, .wrClk, .rdClk, .masterResetN,
    .partialResetN, .offsetLoadSelectN, .serialLoadEnableN, .writeEnableN,
    .readEnableN, .retransmitRequestN, .serialIn, .dataInBus, .memEmptyN,
    .memFirstWord);

  initial clk = 1'b0;
  always #20 clk = ~clk;

  task automatic giveVerdict();
    if (nErrors == 0 && cmpCount > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : giveVerdict

  task automatic chk(input logic [40:0] got, input logic [40:0] exp);
    cmpCount++;
    if (got !== exp) begin
      nErrors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  function automatic logic [31:0] lfsrNext(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0000_0000);
  endfunction : lfsrNext

  task automatic getRnd(output logic [8:0] r);
    rndState = lfsrNext(rndState);
    r = rndState[8:0];
  endtask : getRnd

  task automatic apbXfer(input logic wr, input logic [7:0] a,
                         input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) nErrors++;
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apbXfer

  initial begin
    repeat (20000) @(posedge clk);
    nErrors++;
    giveVerdict();
  end

  initial begin
    {rstn, psel, penable, pwrite, paddr, pwdata} = '0;
    nErrors = 0;
    cmpCount = 0;
    rndState = 32'd79527;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    ctl.masterReset(1'b0, 1'b0);
    chk({fallThroughMode, serialMethod, emptyOffset}, 16'h007f);
    for (int i = 0; i < 5; i++) begin
      getRnd(w[i]);
      ctl.setPins(P_WR, 1'b0, w[i]);
      ctl.pulse(1'b1);
      if (i == 1) begin
        for (int k = 0; k < 3; k++) begin
          ctl.setPins(PAUSE_PAR[4*k +: 4], 1'b1, ~w[i]);
          ctl.pulse(1'b1);
        end
      end
    end
    chk(emptyOffset, {w[1][4:0], w[4]});
    chk(fullOffset, {w[3][4:0], w[2]});
    e = '{w[4], {4'h0, w[1][4:0]}, w[2], {4'h0, w[3][4:0]}};
    for (int i = 0; i < 5; i++) begin
      ctl.setPins(P_RD, 1'b0, 9'h000);
      ctl.pulse(1'b0);
      chk(dataOutBus, e[i % 4]);
      if (i == 1) begin
        ctl.setPins(P_MEMRD, 1'b0, 9'h000);
        ctl.pulse(1'b0);
      end
    end
    apbXfer(1'b0, ADDR_STATUS, 32'h0);
    chk(rdat[8:5], 4'b0101);
    ctl.partialReset();
    apbXfer(1'b0, ADDR_STATUS, 32'h0);
    chk({rdat[8:5], dataOutBus, emptyOffset}, {4'b0101, 9'h0, e[1][4:0], e[0]});
    ctl.setPins(P_RD, 1'b0, 9'h000);
    ctl.pulse(1'b0);
    chk(dataOutBus, e[1]);
    ctl.setMem(1'b1, 9'h0a5);
    ctl.retransmit();
    chk(emptyFlagN, 1'b0);
    ctl.pulse(1'b0);
    chk(emptyFlagN, 1'b0);
    ctl.pulse(1'b0);
    chk(emptyFlagN, 1'b1);
    ctl.masterReset(1'b1, 1'b1);
    apbXfer(1'b0, ADDR_STATUS, 32'h0);
    chk({rdat[8:5], rdat[1:0], emptyOffset}, {6'h03, 14'h03ff});
    for (int i = 0; i < 28; i++) begin
      getRnd(v);
      s[i] = v[0];
      ctl.setPins(P_SER, s[i], 9'h000);
      ctl.pulse(1'b1);
      if (i == 0) chk({almostEmptyValid, almostFullValid}, 2'b00);
      if (i == 9) begin
        for (int k = 0; k < 3; k++) begin
          ctl.setPins(PAUSE_SER[4*k +: 4], ~s[i], v);
          ctl.pulse(1'b1);
        end
      end
    end
    chk({fullOffset, emptyOffset}, s);
    chk({almostEmptyValid, almostFullValid}, 2'b00);
    ctl.setPins(P_IDLE, 1'b0, 9'h000);
    ctl.pulse(1'b1);
    ctl.pulse(1'b1);
    chk({almostEmptyValid, almostFullValid}, 2'b01);
    ctl.pulse(1'b0);
    ctl.pulse(1'b0);
    chk({almostEmptyValid, almostFullValid}, 2'b11);
    ctl.setPins(P_RD, 1'b0, 9'h000);
    ctl.pulse(1'b0);
    chk(dataOutBus, s[8:0]);
    getRnd(v);
    ctl.setMem(1'b1, v);
    repeat (4) @(posedge clk);
    chk(emptyFlagN, 1'b0);
    ctl.retransmit();
    chk(emptyFlagN, 1'b1);
    ctl.pulse(1'b0);
    ctl.pulse(1'b0);
    chk({emptyFlagN, dataOutBus}, {1'b0, v});
    apbXfer(1'b1, ADDR_EMPTY_OFS, 32'hffffffff);
    apbXfer(1'b0, ADDR_EMPTY_OFS, 32'h0);
    chk({err, rdat}, {19'h0, s[13:0]});
    apbXfer(1'b0, 8'h10, 32'h0);
    chk({err, rdat}, {1'b1, 32'h0});
    giveVerdict();
  end
endmodule : fifo_offset_program_retransmit_bench
